// ### exr_cfg.sv
/*
 * excitation current routing, gpio enable, direction and data registers.
 * assumes register requests come from serial interface logic on clk and
 * that the magnitude field comes from the neighbouring control register on clk.
 */
`default_nettype none
// Summary of operation
// - The routing register sits at 0Bh, is read/write and resets to FFh (both sources off).
// - Bits 7:4 route the first source; codes 0000 to 0111 select analog inputs 0 to 7.
// - Code 10x0 selects excitation pin a, 10x1 pin b, and 11xx leaves a source disconnected.
// - Bits 3:0 route the second source with the same code table.
// - Inputs 4 to 7 and the excitation pins are reachable only on the eight-input variant.
// - The gpio enable register sits at 0Ch, is read/write and resets to 00h.
// - An enable bit of 1 gives its shared pin the gpio function, 0 leaves it analog.
// - Gpio bit 0 is the positive reference, bit 1 the negative reference, bits 2-7 the inputs.
// - On the four-gpio variant bits 7:4 of enable and direction read zero and ignore writes.
// - The gpio direction register sits at 0Dh, is read/write and resets to 00h.
// - A direction bit of 0 makes its pin an output, 1 an input.
// - On the eight-input variant all eight enable and direction bits are read/write.
// - Data reads at 0Eh return the stored bit for outputs and the synchronised pad level for inputs; writes store the value, driven on output pins.
// - With magnitude code 000 both current sources stay off whatever the routing says.
module exr_cfg #(
  parameter bit FULL_VARIANT = 1'b1 // eight-input, eight-gpio variant
) (
  input wire logic clk, // 10 MHz device clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire exr_pkg::exr_req_s req, // register request from serial logic
  input wire logic [2:0] excitation_magnitude, // magnitude field, same clock
  input wire logic [7:0] pin_in, // gpio pin levels from the pads
  output logic [7:0] rdata, // read data
  output logic rvalid, // read data valid pulse
  output var exr_pkg::exr_dest_s first_dest, // first source destination
  output var exr_pkg::exr_dest_s second_dest, // second source destination
  output logic [7:0] pin_out, // gpio pin output levels
  output logic [7:0] pin_oe, // gpio pin output enables
  output logic [7:0] pin_gpio_mode // pin taken from its analog function
);
  // ****************************************************
  // reset release
  // ****************************************************
  logic [1:0] rst_sync_reg;
  wire logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ****************************************************
  // pad input synchroniser
  // ****************************************************
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
    end else if (ce) begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ****************************************************
  // register decode
  // ****************************************************
  logic [7:0] route_reg;
  logic [7:0] en_reg;
  logic [7:0] dir_reg;
  logic [7:0] data_reg;
  wire logic [7:0] wmask;
  wire logic wr_route;
  wire logic wr_en;
  wire logic wr_dir;
  wire logic wr_data;
  wire logic [7:0] data_view;
  logic [7:0] rsel;

  assign wmask = FULL_VARIANT ? exr_pkg::MASK_FULL : exr_pkg::MASK_SMALL;
  assign wr_route = req.wr && (req.addr == exr_pkg::ADDR_ROUTE);
  assign wr_en = req.wr && (req.addr == exr_pkg::ADDR_PIN_EN);
  assign wr_dir = req.wr && (req.addr == exr_pkg::ADDR_PIN_DIR);
  assign wr_data = req.wr && (req.addr == exr_pkg::ADDR_PIN_DATA);
  // outputs read back the stored bit, inputs the synchronised pad level
  assign data_view = ((data_reg & ~dir_reg) | (pin_sync_reg & dir_reg)) & wmask;

  always_comb begin
    case (req.addr)
      exr_pkg::ADDR_ROUTE: rsel = route_reg;
      exr_pkg::ADDR_PIN_EN: rsel = en_reg & wmask;
      exr_pkg::ADDR_PIN_DIR: rsel = dir_reg & wmask;
      exr_pkg::ADDR_PIN_DATA: rsel = data_view;
      default: rsel = exr_pkg::READ_UNMAPPED;
    endcase
  end

  // ****************************************************
  // configuration registers
  // ****************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      route_reg <= exr_pkg::ROUTE_RESET;
      en_reg <= exr_pkg::PIN_EN_RESET;
      dir_reg <= exr_pkg::PIN_DIR_RESET;
      data_reg <= exr_pkg::PIN_DATA_RESET;
    end else if (ce) begin
      if (wr_route) begin
        route_reg <= req.wdata;
      end
      if (wr_en) begin
        en_reg <= req.wdata & wmask;
      end
      if (wr_dir) begin
        dir_reg <= req.wdata & wmask;
      end
      if (wr_data) begin
        data_reg <= req.wdata & wmask;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else if (ce) begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= rsel;
      end
    end
  end

  // ****************************************************
  // current routing
  // ****************************************************
  wire logic power_on;
  exr_pkg::exr_dest_s first_next;
  exr_pkg::exr_dest_s second_next;

  assign power_on = (excitation_magnitude != exr_pkg::MAG_OFF);

  exr_route_dec u_first_dec (
    .code(route_reg[exr_pkg::FIRST_ROUTE_LSB +: exr_pkg::ROUTE_W]),
    .power_on(power_on),
    .full_variant(FULL_VARIANT),
    .dest(first_next)
  );

  exr_route_dec u_second_dec (
    .code(route_reg[exr_pkg::SECOND_ROUTE_LSB +: exr_pkg::ROUTE_W]),
    .power_on(power_on),
    .full_variant(FULL_VARIANT),
    .dest(second_next)
  );

  // ****************************************************
  // pin outputs
  // ****************************************************
  // bit 0 positive reference, bit 1 negative reference, bits 2-7 analog inputs
  wire logic [7:0] oe_next;

  assign oe_next = en_reg & ~dir_reg & wmask;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_dest <= exr_pkg::DEST_NONE;
      second_dest <= exr_pkg::DEST_NONE;
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pin_gpio_mode <= 8'h00;
    end else if (ce) begin
      first_dest <= first_next;
      second_dest <= second_next;
      pin_oe <= oe_next;
      pin_out <= data_reg & oe_next;
      pin_gpio_mode <= en_reg & wmask;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  sequence s_write(logic [3:0] a);
    ce && req.wr && req.addr == a;
  endsequence

  sequence s_read(logic [3:0] a);
    ce && req.rd && req.addr == a;
  endsequence

  chk_route_write: assert property (@(posedge clk) disable iff (!rst_n)
    s_write(exr_pkg::ADDR_ROUTE) |=> route_reg == $past(req.wdata))
    else $error("routing register did not take the write");

  chk_route_reset: assert property (@(posedge clk)
    $rose(rst_n) |-> route_reg == exr_pkg::ROUTE_RESET && first_dest == exr_pkg::DEST_NONE)
    else $error("routing register not at reset value");

  chk_first_ain: assert property (@(posedge clk) disable iff (!rst_n)
    ce && power_on && !route_reg[7] && (FULL_VARIANT || !route_reg[6])
    |=> first_dest.ain == (8'h01 << $past(route_reg[6:4])) && !first_dest.pin_a)
    else $error("first source not on the selected input");

  chk_first_off: assert property (@(posedge clk) disable iff (!rst_n)
    ce && route_reg[7:6] == 2'b11 |=> first_dest == exr_pkg::DEST_NONE)
    else $error("first source connected on a disconnect code");

  chk_second_pin: assert property (@(posedge clk) disable iff (!rst_n)
    ce && power_on && FULL_VARIANT && route_reg[3:2] == 2'b10
    |=> second_dest.pin_b == $past(route_reg[0]) && second_dest.pin_a == !$past(route_reg[0]))
    else $error("second source on the wrong excitation pin");

  chk_small_limit: assert property (@(posedge clk) disable iff (!rst_n)
    !FULL_VARIANT |-> first_dest.ain[7:4] == 4'h0 && !first_dest.pin_a && !second_dest.pin_b)
    else $error("large-variant destination used on small variant");

  chk_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
    s_read(exr_pkg::ADDR_PIN_EN) ##0 !FULL_VARIANT |=> rvalid && rdata[7:4] == 4'h0)
    else $error("upper enable bits not read as zero");

  chk_en_write: assert property (@(posedge clk) disable iff (!rst_n)
    s_write(exr_pkg::ADDR_PIN_EN) ##1 ce |=> pin_gpio_mode == ($past(req.wdata, 2) & wmask))
    else $error("enable write not reflected on the pins");

  chk_dir_read: assert property (@(posedge clk) disable iff (!rst_n)
    s_write(exr_pkg::ADDR_PIN_DIR) ##1 s_read(exr_pkg::ADDR_PIN_DIR)
    |=> rdata == ($past(req.wdata, 2) & wmask))
    else $error("direction register readback mismatch");

  chk_data_read: assert property (@(posedge clk) disable iff (!rst_n)
    s_read(exr_pkg::ADDR_PIN_DATA)
    |=> rdata == (($past(data_reg) & ~$past(dir_reg) & wmask)
    | ($past(pin_sync_reg) & $past(dir_reg) & wmask)))
    else $error("data readback does not follow direction");

  chk_mag_off: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !power_on |=> first_dest == exr_pkg::DEST_NONE && second_dest == exr_pkg::DEST_NONE)
    else $error("current routed while magnitude is off");

  chk_drive_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> pin_oe == ($past(en_reg) & ~$past(dir_reg) & wmask) && (pin_out & ~pin_oe) == 8'h00)
    else $error("pin driven outside gpio output mode");

  chk_route_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(ce && req.wr && req.addr == exr_pkg::ADDR_ROUTE) |=> $stable(route_reg))
    else $error("routing register changed without a write");

  chk_gpio_reset: assert property (@(posedge clk)
    $rose(rst_n) |-> en_reg == exr_pkg::PIN_EN_RESET && dir_reg == exr_pkg::PIN_DIR_RESET)
    else $error("gpio registers not at reset value");

  chk_first_pin: assert property (@(posedge clk) disable iff (!rst_n)
    ce && power_on && FULL_VARIANT && route_reg[7:6] == 2'b10
    |=> first_dest.pin_b == $past(route_reg[4]) && first_dest.pin_a == !$past(route_reg[4]))
    else $error("first source on the wrong excitation pin");

  chk_second_ain: assert property (@(posedge clk) disable iff (!rst_n)
    ce && power_on && !route_reg[3] && (FULL_VARIANT || !route_reg[2])
    |=> second_dest.ain == (8'h01 << $past(route_reg[2:0])) && !second_dest.pin_b)
    else $error("second source not on the selected input");

  chk_second_off: assert property (@(posedge clk) disable iff (!rst_n)
    ce && route_reg[3:2] == 2'b11 |=> second_dest == exr_pkg::DEST_NONE)
    else $error("second source connected on a disconnect code");

  chk_small_route: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !FULL_VARIANT && (route_reg[7] ^ route_reg[6]) |=> first_dest == exr_pkg::DEST_NONE)
    else $error("large-variant code routed on small variant");

  chk_dir_write: assert property (@(posedge clk) disable iff (!rst_n)
    s_write(exr_pkg::ADDR_PIN_DIR) |=> dir_reg == ($past(req.wdata) & wmask))
    else $error("direction register did not take the write");

  chk_full_rw: assert property (@(posedge clk) disable iff (!rst_n)
    s_write(exr_pkg::ADDR_PIN_EN) ##0 FULL_VARIANT |=> en_reg == $past(req.wdata))
    else $error("enable register lost bits on the large variant");

  chk_upper_dir: assert property (@(posedge clk) disable iff (!rst_n)
    s_read(exr_pkg::ADDR_PIN_DIR) ##0 !FULL_VARIANT |=> rvalid && rdata[7:4] == 4'h0)
    else $error("upper direction bits not read as zero");

  chk_mode_map: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> pin_gpio_mode == ($past(en_reg) & wmask))
    else $error("gpio mode does not follow the enable register");

  chk_data_store: assert property (@(posedge clk) disable iff (!rst_n)
    s_write(exr_pkg::ADDR_PIN_DATA) |=> data_reg == ($past(req.wdata) & wmask))
    else $error("data write not stored");

  chk_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(route_reg) && $stable(en_reg) && $stable(dir_reg) && $stable(data_reg))
    else $error("register changed while the clock enable was low");

  chk_read_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !req.rd |=> !rvalid)
    else $error("read valid without a read strobe");
endmodule // exr_cfg
`default_nettype wire

// ### exr_pkg.sv
/*
 * shared constants and types for the excitation routing and gpio config block.
 * assumes one 10 MHz device clock and a register port from the serial interface logic.
 */
`default_nettype none
package exr_pkg;
  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [3:0] ADDR_ROUTE = 4'hb;
  localparam logic [3:0] ADDR_PIN_EN = 4'hc;
  localparam logic [3:0] ADDR_PIN_DIR = 4'hd;
  localparam logic [3:0] ADDR_PIN_DATA = 4'he;
  // ****************************************************
  // reset values and masks
  // ****************************************************
  localparam logic [7:0] ROUTE_RESET = 8'hff;
  localparam logic [7:0] PIN_EN_RESET = 8'h00;
  localparam logic [7:0] PIN_DIR_RESET = 8'h00;
  localparam logic [7:0] PIN_DATA_RESET = 8'h00;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_SMALL = 8'h0f;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [2:0] MAG_OFF = 3'h0;
  // ****************************************************
  // field positions of the routing register and its codes
  // ****************************************************
  localparam int FIRST_ROUTE_LSB = 4;
  localparam int SECOND_ROUTE_LSB = 0;
  localparam int ROUTE_W = 4;
  localparam int CODE_KIND_BIT = 3;
  localparam int CODE_PIN_BIT = 2;
  localparam int CODE_SEL_BIT = 0;
  localparam logic [2:0] SMALL_AIN_LIMIT = 3'h4;
  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } exr_req_s;
  typedef struct packed {
    logic [7:0] ain;
    logic pin_a;
    logic pin_b;
  } exr_dest_s;
  localparam exr_dest_s DEST_NONE = '0;
endpackage : exr_pkg
`default_nettype wire

// ### exr_route_dec.sv
/*
 * decodes one 4-bit routing field into a one-hot current destination.
 * assumes the caller registers the result; purely combinational.
 */
`default_nettype none
module exr_route_dec (
  input wire logic [3:0] code, // routing field
  input wire logic power_on, // magnitude field nonzero
  input wire logic full_variant, // eight-input variant
  output var exr_pkg::exr_dest_s dest // decoded destination
);
  // ****************************************************
  // decode
  // ****************************************************
  wire logic to_ain;
  wire logic to_pin;
  wire logic ain_ok;
  wire logic [2:0] ain_idx;
  exr_pkg::exr_dest_s dec;

  assign ain_idx = code[2:0];
  assign to_ain = ~code[exr_pkg::CODE_KIND_BIT];
  // 11xx falls through as disconnected
  assign to_pin = code[exr_pkg::CODE_KIND_BIT] & ~code[exr_pkg::CODE_PIN_BIT];
  // upper inputs and dedicated pins exist only on the large variant
  assign ain_ok = full_variant | (ain_idx < exr_pkg::SMALL_AIN_LIMIT);

  always_comb begin
    dec = exr_pkg::DEST_NONE;
    if (power_on) begin
      if (to_ain && ain_ok) begin
        dec.ain = 8'h01 << ain_idx;
      end else if (to_pin && full_variant) begin
        dec.pin_b = code[exr_pkg::CODE_SEL_BIT];
        dec.pin_a = ~code[exr_pkg::CODE_SEL_BIT];
      end
    end
  end

  assign dest = dec;
endmodule // exr_route_dec
`default_nettype wire

// ### exr_host.sv
/*
 * host model: issues register writes and reads on the request port.
 * assumes one clock shared with the block; requests change just after rising edges.
 */
`default_nettype none
module exr_host (
  input wire logic clk, // device clock
  output var exr_pkg::exr_req_s req, // register request
  input wire logic [7:0] rdata, // read data
  input wire logic rvalid // read data valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // one-cycle write strobe, then idle for one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  // the answer stands for the cycle after the strobe is taken
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    d = rvalid ? rdata : 8'hxx;
  endtask
  // write then read back on the very next edge
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    q = rvalid ? rdata : 8'hxx;
  endtask
endmodule // exr_host
`default_nettype wire

// ### tb_excitation_route_and_gpio_config.sv
/*
 * self-checking bench: both variants side by side behind one host model.
 * assumes exr_pkg, exr_route_dec, exr_cfg and exr_host are compiled first.
 */
`default_nettype none
module tb_excitation_route_and_gpio_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [2:0] mag = 3'h0;
  logic [7:0] pad_lvl = 8'hff;
  exr_pkg::exr_req_s req;
  logic [7:0] rdata, rdata_s, pout, pout_s, poe, poe_s, mode, mode_s, f, s;
  logic rvalid, rvalid_s;
  exr_pkg::exr_dest_s d1, d2, d1_s, d2_s;
  int miscompares = 0;
  int compares = 0;
  // ****************************************************
  // block under test, pads and host
  // ****************************************************
  exr_cfg #(.FULL_VARIANT(1'b1)) DUT (.clk(clk), .resetn(resetn), .ce(ce), .req(req),
    .excitation_magnitude(mag), .pin_in((pout & poe) | (pad_lvl & ~poe)), .rdata(rdata),
    .rvalid(rvalid), .first_dest(d1), .second_dest(d2), .pin_out(pout), .pin_oe(poe),
    .pin_gpio_mode(mode));
  exr_cfg #(.FULL_VARIANT(1'b0)) DUT_SMALL (.clk(clk), .resetn(resetn), .ce(ce), .req(req),
    .excitation_magnitude(mag), .pin_in((pout_s & poe_s) | (pad_lvl & ~poe_s)),
    .rdata(rdata_s), .rvalid(rvalid_s), .first_dest(d1_s), .second_dest(d2_s), .pin_out(pout_s),
    .pin_oe(poe_s), .pin_gpio_mode(mode_s));
  exr_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  initial begin
    forever #50 clk = ~clk;
  end
  // ****************************************************
  // helpers
  // ****************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd2(input logic [3:0] a);
    host.rd(a, f);
    s = rvalid_s ? rdata_s : 8'hxx;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic exr_pkg::exr_dest_s dexp(input logic [3:0] c, input bit full);
    dexp = exr_pkg::DEST_NONE;
    if (c < 4'h4 || (full && c < 4'h8)) dexp.ain[c[2:0]] = 1'b1;
    if (full && c[3:2] == 2'b10) begin
      dexp.pin_a = ~c[0];
      dexp.pin_b = c[0];
    end
  endfunction
  task automatic complete_run;
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic test_reset;
    rd2(exr_pkg::ADDR_ROUTE);
    check({f, s}, 32'hffff);
    rd2(exr_pkg::ADDR_PIN_EN);
    check({f, s}, 32'h0);
    rd2(exr_pkg::ADDR_PIN_DIR);
    check({f, s}, 32'h0);
    rd2(4'h3);
    check({f, s}, 32'h0);
    check({poe, mode, poe_s, mode_s}, 32'h0);
    check({d1, d2}, 32'h0);
  endtask
  task automatic test_route;
    logic [3:0] c;
    @(posedge clk);
    mag <= 3'h1;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      host.wr(exr_pkg::ADDR_ROUTE, {c, ~c});
      settle(2);
      check({d1, d2}, {dexp(c, 1'b1), dexp(~c, 1'b1)});
      check({d1_s, d2_s}, {dexp(c, 1'b0), dexp(~c, 1'b0)});
      rd2(exr_pkg::ADDR_ROUTE);
      check({f, s}, {c, ~c, c, ~c});
    end
  endtask
  task automatic test_mag_off;
    host.wr(exr_pkg::ADDR_ROUTE, 8'h01);
    settle(2);
    check({d1, d2}, {10'h004, 10'h008});
    @(posedge clk);
    mag <= 3'h0;
    settle(2);
    check({d1, d2, 2'b00, d1_s}, 32'h0);
  endtask
  task automatic test_gpio;
    host.wr(exr_pkg::ADDR_PIN_EN, 8'hff);
    host.wr(exr_pkg::ADDR_PIN_DIR, 8'h3c);
    host.wr(exr_pkg::ADDR_PIN_DATA, 8'ha5);
    settle(3);
    check({poe, poe_s}, 32'hc303);
    check({pout, pout_s}, 32'h8101);
    check({mode, mode_s}, 32'hff0f);
    rd2(exr_pkg::ADDR_PIN_EN);
    check({f, s}, 32'hff0f);
    rd2(exr_pkg::ADDR_PIN_DIR);
    check({f, s}, 32'h3c0c);
    rd2(exr_pkg::ADDR_PIN_DATA);
    check({f, s}, 32'hbd0d);
    @(posedge clk);
    pad_lvl <= 8'h00;
    settle(4);
    rd2(exr_pkg::ADDR_PIN_DATA);
    check({f, s}, 32'h8101);
    host.wr(exr_pkg::ADDR_PIN_DIR, 8'h00);
    settle(2);
    check({pout, pout_s, poe, poe_s}, 32'ha505ff0f);
  endtask
  task automatic test_ce;
    @(posedge clk);
    ce <= 1'b0;
    host.wr(exr_pkg::ADDR_PIN_EN, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    rd2(exr_pkg::ADDR_PIN_EN);
    check({f, s}, 32'hff0f);
  endtask
  task automatic test_back_to_back;
    host.wr_rd(exr_pkg::ADDR_PIN_DIR, 8'h5a, f);
    s = rvalid_s ? rdata_s : 8'hxx;
    check({f, s}, 32'h5a0a);
  endtask
  task automatic test_reset_again;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    test_reset();
  endtask
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    test_reset();
    test_route();
    test_mag_off();
    test_gpio();
    test_ce();
    test_back_to_back();
    test_reset_again();
    complete_run();
  end
  initial begin
    #(3000 * 100);
    miscompares++;
    complete_run();
  end
endmodule // tb_excitation_route_and_gpio_config
`default_nettype wire
